// ---- host_port_pkg.sv ----
// host port page and lock package: register offsets, field positions, reset values, access carrier
// assumes a serial protocol engine that delivers one byte access at a time
package host_port_pkg;
   localparam logic [6:0] OFS_SLAVE_ADDR = 7'h3E;
   localparam logic [6:0] OFS_PORT_LOCK = 7'h7E;
   localparam logic [6:0] OFS_PAGE_SEL = 7'h7F;
   localparam logic [7:0] RST_SLAVE_ADDR = 8'h38;
   localparam logic [7:0] RST_PORT_LOCK = 8'h00;
   localparam logic [7:0] RST_PAGE_SEL = 8'h00;
   localparam int LOCK_BIT = 7;
   localparam int RESULT_BIT = 0;
   localparam int ADDR_LSB = 1;
   localparam int ADDR_MSB = 6;
   localparam int PAGE_W = 4;
   localparam int OFS_W = 7;
   localparam logic [7:0] LAST_PAGE = 8'h0F;
   localparam logic [3:0] HOME_PAGE = 4'h0;

   typedef struct packed {
      logic write;
      logic [6:0] offset;
      logic [7:0] wdata;
   } host_access_t;

   typedef struct packed {
      logic write;
      logic [10:0] addr;
      logic [7:0] wdata;
   } map_access_t;
endpackage

// ---- page_window_decode.sv ----
// page window decode: joins page select and in-page offset into a flat map address
// assumes page select and offset come from logic on the same clock
`timescale 1ns/100ps
module page_window_decode
   import host_port_pkg::*;
(
   // inputs
   input wire logic [7:0] page_sel,
   input wire logic [6:0] offset,
   // outputs
   output logic [10:0] flat_addr,
   output logic page_valid,
   output logic port_hit,
   output logic home_hit
);
   always_comb begin
      flat_addr = {page_sel[PAGE_W-1:0], offset};
      page_valid = (page_sel <= LAST_PAGE);
      port_hit = (offset == OFS_PORT_LOCK) || (offset == OFS_PAGE_SEL);
      home_hit = (page_sel[PAGE_W-1:0] == HOME_PAGE) && page_valid && (offset == OFS_SLAVE_ADDR);
   end
endmodule

// ---- host_port_regs.sv ----
// host port control registers: slave address report, write lock with access result, page select
// assumes the serial engine gives one-cycle access strobes and the map answers in the same cycle
`timescale 1ns/100ps
module host_port_regs
   import host_port_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // pins
   input wire logic i2c_mode,
   input wire logic [5:0] i2c_addr_upper,
   // access from the serial engine
   input wire logic acc_valid,
   input wire host_access_t acc_req,
   output logic acc_done,
   output logic [7:0] acc_rdata,
   // rest of the register map
   output logic map_valid,
   output map_access_t map_req,
   input wire logic [7:0] map_rdata,
   input wire logic map_err,
   // state seen by the rest of the device
   output logic [7:0] page_out,
   output logic lock_out
);
   logic [1:0] mode_sync_reg;
   logic [5:0] addr_sync1_reg;
   logic [5:0] addr_sync2_reg;
   logic [7:0] slave_addr_reg, slave_addr_next;
   logic lock_reg, lock_next;
   logic result_reg, result_next;
   logic [7:0] page_reg, page_next;
   logic done_reg, done_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [10:0] flat_addr;
   logic page_valid, port_hit, home_hit;

   page_window_decode u_decode (
      .page_sel(page_reg),
      .offset(acc_req.offset),
      .flat_addr(flat_addr),
      .page_valid(page_valid),
      .port_hit(port_hit),
      .home_hit(home_hit)
   );

   // pin synchronisers
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mode_sync_reg <= 2'h0;
         addr_sync1_reg <= 6'h00;
         addr_sync2_reg <= 6'h00;
      end else begin
         mode_sync_reg <= {mode_sync_reg[0], i2c_mode};
         addr_sync1_reg <= i2c_addr_upper;
         addr_sync2_reg <= addr_sync1_reg;
      end
   end

   // forward accesses outside the port registers to the selected page, unless that page is above LAST_PAGE
   always_comb begin
      map_valid = acc_valid && !port_hit && !home_hit && page_valid;
      map_req.write = acc_req.write && !lock_reg;
      map_req.addr = flat_addr;
      map_req.wdata = acc_req.wdata;
   end

   always_comb begin
      slave_addr_next = slave_addr_reg;
      lock_next = lock_reg;
      result_next = result_reg;
      page_next = page_reg;
      done_next = acc_valid;
      rdata_next = rdata_reg;
      if (mode_sync_reg[1]) begin
         slave_addr_next = {1'h0, addr_sync2_reg, 1'h0};
      end
      if (acc_valid) begin
         result_next = 1'h0;
         rdata_next = 8'h00;
         if (acc_req.offset == OFS_PORT_LOCK) begin
            rdata_next[LOCK_BIT] = lock_reg;
            rdata_next[RESULT_BIT] = result_reg;
            if (acc_req.write) begin
               lock_next = acc_req.wdata[LOCK_BIT];
            end
         end else if (acc_req.offset == OFS_PAGE_SEL) begin
            rdata_next = page_reg;
            if (acc_req.write) begin
               if (lock_reg) begin
                  result_next = 1'h1;
               end else begin
                  page_next = acc_req.wdata;
               end
            end
         end else if (home_hit) begin
            rdata_next = slave_addr_reg;
            if (acc_req.write) begin
               result_next = 1'h1;
            end
         end else if (!page_valid) begin
            result_next = 1'h1;
         end else begin
            rdata_next = map_rdata;
            if ((acc_req.write && lock_reg) || map_err) begin
               result_next = 1'h1;
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         slave_addr_reg <= RST_SLAVE_ADDR;
         lock_reg <= RST_PORT_LOCK[LOCK_BIT];
         result_reg <= RST_PORT_LOCK[RESULT_BIT];
         page_reg <= RST_PAGE_SEL;
         done_reg <= 1'h0;
         rdata_reg <= 8'h00;
      end else begin
         slave_addr_reg <= slave_addr_next;
         lock_reg <= lock_next;
         result_reg <= result_next;
         page_reg <= page_next;
         done_reg <= done_next;
         rdata_reg <= rdata_next;
      end
   end

   always_comb begin
      acc_done = done_reg;
      acc_rdata = rdata_reg;
      page_out = page_reg;
      lock_out = lock_reg;
   end

   sequence s_locked_page_write;
      acc_valid && acc_req.write && (acc_req.offset == OFS_PAGE_SEL) && lock_reg;
   endsequence

   sequence s_open_page_write;
      acc_valid && acc_req.write && (acc_req.offset == OFS_PAGE_SEL) && !lock_reg;
   endsequence

   a_i2c_addr_report: assert property (
      @(posedge core_clk) disable iff (reset)
      mode_sync_reg[1] |=> slave_addr_reg[ADDR_MSB:ADDR_LSB] == $past(addr_sync2_reg)
   ) else $error("slave address does not follow the strap pins");

   a_locked_page_hold: assert property (
      @(posedge core_clk) disable iff (reset)
      s_locked_page_write |=> (page_reg == $past(page_reg)) && result_reg && acc_done
   ) else $error("page select changed while locked");

   a_locked_map_read: assert property (
      @(posedge core_clk) disable iff (reset)
      map_valid && lock_reg |-> !map_req.write
   ) else $error("map write passed while locked");

   a_locked_map_result: assert property (
      @(posedge core_clk) disable iff (reset)
      map_valid && acc_req.write && lock_reg |=> result_reg && acc_done
   ) else $error("refused map write not reported");

   a_open_page_write: assert property (
      @(posedge core_clk) disable iff (reset)
      s_open_page_write |=> page_reg == $past(acc_req.wdata)
   ) else $error("page select write lost while unlocked");

   a_result_good: assert property (
      @(posedge core_clk) disable iff (reset)
      acc_valid && !acc_req.write && (acc_req.offset == OFS_PAGE_SEL) |=> !result_reg ##1 !result_reg || acc_done
   ) else $error("result bit not cleared after good access");

   a_done_timing: assert property (
      @(posedge core_clk) disable iff (reset)
      acc_valid |=> acc_done
   ) else $error("access not answered in one cycle");

   a_page_address: assert property (
      @(posedge core_clk) disable iff (reset)
      map_valid |-> map_req.addr == {page_reg[PAGE_W-1:0], acc_req.offset}
   ) else $error("map address does not match selected page");

   a_reserved_page: assert property (
      @(posedge core_clk) disable iff (reset)
      acc_valid && (page_reg > LAST_PAGE) && !port_hit |-> !map_valid ##1 result_reg
   ) else $error("reserved page access not refused");
endmodule

// ---- map_model.sv ----
// rest-of-map model: byte memory that answers in the access cycle
// assumes map_req is steady while map_valid is high
`timescale 1ns/100ps
module map_model
   import host_port_pkg::*;
(
   // clock
   input wire logic core_clk,
   // map side
   input wire logic map_valid,
   input wire map_access_t map_req,
   input wire logic err_en,
   output logic [7:0] map_rdata,
   output logic map_err
);
   logic [7:0] mem [0:2047];
   logic [7:0] last_reg;
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      last_reg = 8'h00;
   end
   always @(posedge core_clk) begin
      if (map_valid) begin
         last_reg <= mem[map_req.addr];
         if (map_req.write) mem[map_req.addr] <= map_req.wdata;
      end
   end
   // released bus shows the inverse of the last value
   assign map_rdata = map_valid ? mem[map_req.addr] : ~last_reg;
   assign map_err = map_valid & err_en;
endmodule

// ---- tb.sv ----
// testbench for the host port registers: byte accesses on the engine-side strobe
// assumes map_model stands for the rest of the register map
`timescale 1ns/100ps
module tb;
   import host_port_pkg::*;
   logic core_clk = 1'h0;
   logic reset = 1'h1;
   logic i2c_mode = 1'h0;
   logic [5:0] i2c_addr_upper = 6'h15;
   logic acc_valid = 1'h0;
   host_access_t acc_req = '0;
   logic err_en = 1'h0;
   logic acc_done, map_valid, map_err, lock_out;
   logic [7:0] acc_rdata, map_rdata, page_out, rd_q;
   map_access_t map_req;
   int errors = 0;
   int num_checks = 0;
   always #10 core_clk = ~core_clk;
   host_port_regs u_host_port_regs (.core_clk(core_clk), .reset(reset), .i2c_mode(i2c_mode),
      .i2c_addr_upper(i2c_addr_upper), .acc_valid(acc_valid), .acc_req(acc_req), .acc_done(acc_done),
      .acc_rdata(acc_rdata), .map_valid(map_valid), .map_req(map_req), .map_rdata(map_rdata),
      .map_err(map_err), .page_out(page_out), .lock_out(lock_out));
   map_model u_map_model (.core_clk(core_clk), .map_valid(map_valid), .map_req(map_req),
      .err_en(err_en), .map_rdata(map_rdata), .map_err(map_err));
   task test_done;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task acc(input logic wr, input logic [6:0] ofs, input logic [7:0] d);
      @(posedge core_clk);
      acc_valid <= 1'h1;
      acc_req <= '{write: wr, offset: ofs, wdata: d};
      @(posedge core_clk);
      acc_valid <= 1'h0;
      for (int i = 0; i < 4; i++) begin
         #1;
         if (acc_done === 1'h1) begin
            rd_q = acc_rdata;
            return;
         end
         @(posedge core_clk);
      end
      $display("[ERR] %0t access not answered", $time);
      errors++;
      test_done();
   endtask
   task rd(input logic [6:0] ofs, input logic [7:0] exp);
      acc(1'h0, ofs, 8'h00);
      chk(rd_q, exp);
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      reset <= 1'h0;
      rd(OFS_PORT_LOCK, RST_PORT_LOCK);
      rd(OFS_PAGE_SEL, RST_PAGE_SEL);
      rd(OFS_SLAVE_ADDR, RST_SLAVE_ADDR);
      @(posedge core_clk) i2c_mode <= 1'h1;
      repeat (5) @(posedge core_clk);
      rd(OFS_SLAVE_ADDR, 8'h2A);
      acc(1'h1, OFS_SLAVE_ADDR, 8'hFF);
      rd(OFS_PORT_LOCK, 8'h01);
      rd(OFS_SLAVE_ADDR, 8'h2A);
      acc(1'h1, OFS_PAGE_SEL, 8'h03);
      rd(OFS_PORT_LOCK, 8'h00);
      rd(OFS_PAGE_SEL, 8'h03);
      acc(1'h1, 7'h10, 8'hA5);
      chk(u_map_model.mem[11'h190], 8'hA5);
      rd(7'h10, 8'hA5);
      acc(1'h1, OFS_PAGE_SEL, 8'h04);
      rd(7'h10, 8'h00);
      acc(1'h1, OFS_PAGE_SEL, LAST_PAGE);
      acc(1'h1, 7'h00, 8'h5C);
      chk(u_map_model.mem[11'h780], 8'h5C);
      // reserved page value stops map traffic
      acc(1'h1, OFS_PAGE_SEL, 8'h10);
      rd(7'h00, 8'h00);
      rd(OFS_PORT_LOCK, 8'h01);
      acc(1'h1, OFS_PAGE_SEL, 8'h03);
      acc(1'h1, OFS_PORT_LOCK, 8'h80);
      chk({7'h00, lock_out}, 8'h01);
      acc(1'h1, OFS_PAGE_SEL, 8'h05);
      rd(OFS_PORT_LOCK, 8'h81);
      chk(page_out, 8'h03);
      acc(1'h1, 7'h10, 8'h5A);
      chk(u_map_model.mem[11'h190], 8'hA5);
      acc(1'h1, OFS_PORT_LOCK, 8'h00);
      acc(1'h1, OFS_PAGE_SEL, 8'h05);
      rd(OFS_PAGE_SEL, 8'h05);
      @(posedge core_clk) err_en <= 1'h1;
      acc(1'h0, 7'h10, 8'h00);
      @(posedge core_clk) err_en <= 1'h0;
      rd(OFS_PORT_LOCK, 8'h01);
      // reset in mid-run while locked on page 5 restores the reset page and lock values; the slave address reloads from the strap pins
      acc(1'h1, OFS_PORT_LOCK, 8'h80);
      @(posedge core_clk) reset <= 1'h1;
      repeat (3) @(posedge core_clk);
      reset <= 1'h0;
      chk(page_out, RST_PAGE_SEL);
      chk({7'h00, lock_out}, {7'h00, RST_PORT_LOCK[LOCK_BIT]});
      rd(OFS_PORT_LOCK, RST_PORT_LOCK);
      rd(OFS_SLAVE_ADDR, 8'h2A);
      acc(1'h1, OFS_PAGE_SEL, 8'h02);
      rd(OFS_PAGE_SEL, 8'h02);
      test_done();
   end
endmodule
